// ===== hw/frs_row_buffer.sv
`default_nettype none
module frs_row_buffer #(
  parameter int WORDS = 32,
  parameter int AW    = 5,
  parameter int DW    = 24
) (
  input  wire logic          mclk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);
  logic [DW-1:0] mem [WORDS];

  // Write port and registered read port
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // frs_row_buffer
`default_nettype wire

// ===== hw/frs_sequencer.sv
`include "frs_consts.svh"
`default_nettype none
module frs_sequencer
  import frs_pkg::*;
#(
  parameter int ERASE_CYCLES = `FRS_ERASE_TIME_US * `FRS_CLK_MHZ,
  parameter int PROG_CYCLES  = `FRS_PROG_TIME_US * `FRS_CLK_MHZ,
  parameter int ROW_WORDS    = `FRS_ROW_WORDS,
  parameter int DW           = 24
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  output logic             cpu_stall,
  output logic             flash_erase,
  output logic             flash_prog,
  output logic      [23:0] flash_addr,
  output logic      [DW-1:0] flash_wdata,
  output logic             flash_wr
);
  localparam int AW = $clog2(ROW_WORDS);

  typedef struct packed {
    frs_state_type state;
    logic [15:0]   table_page;
    logic [15:0]   row_offset;
    logic [6:0]    op_sel;
    logic          permit;
    logic          start;
    logic [1:0]    key_stage;
    logic [31:0]   count;
    logic [AW:0]   word;
    logic [AW-1:0] buf_addr;
    logic [7:0]    buf_hi;
    logic [15:0]   rdata;
    logic          stall;
    logic          erase_o;
    logic          prog_o;
    logic [23:0]   faddr;
    logic          fwr;
  } frs_regs_type;

  frs_regs_type r;
  frs_regs_type next_r;
  logic [DW-1:0] buf_rdata;
  logic          buf_wr;
  logic [AW-1:0] buf_raddr;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_wr(input logic [7:0] a, input logic [7:0] off);
    return reg_wr && (a == off);
  endfunction

  function automatic logic [23:0] row_base(input logic [15:0] pg, input logic [15:0] off);
    // Align to a 32-word row, two address units per word
    return {pg[7:0], off[15:6], 6'h00};
  endfunction

  // ----------------------------------------------------------------
  // Row write buffer
  // ----------------------------------------------------------------
  // Buffer loads only while idle
  assign buf_wr = is_wr(reg_addr, `FRS_OFF_BUF_DATA) && r.state == FRS_IDLE;
  // Read one word behind the counter so the data meets its write strobe
  assign buf_raddr = AW'(r.word - 1'b1);

  frs_row_buffer #(.WORDS(ROW_WORDS), .AW(AW), .DW(DW)) u_buf (
    .mclk    (mclk),
    .wr_en   (buf_wr),
    .wr_addr (r.buf_addr),
    .wr_data ({r.buf_hi, reg_wdata}),
    .rd_addr (buf_raddr),
    .rd_data (buf_rdata)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic key_hit;
    logic go;
    key_hit = 1'b0;
    go      = 1'b0;
    next_r  = r;
    next_r.fwr = 1'b0;
    next_r.rdata = 16'h0000;
    // Register writes only while idle; the core is stalled otherwise
    if (reg_wr && r.state == FRS_IDLE) begin
      // Any write other than the expected key disarms
      if (reg_addr == `FRS_OFF_UNLOCK_KEY) begin
        key_hit = 1'b1;
        if (reg_wdata[7:0] == `FRS_KEY_FIRST) begin
          next_r.key_stage = 2'h1;
        end else if (reg_wdata[7:0] == `FRS_KEY_SECOND && r.key_stage == 2'h1) begin
          next_r.key_stage = 2'h2;
        end else begin
          next_r.key_stage = 2'h0;
        end
      end
      if (!key_hit) begin
        next_r.key_stage = 2'h0;
      end
      case (reg_addr)
        `FRS_OFF_TABLE_PAGE: next_r.table_page = reg_wdata;
        `FRS_OFF_ROW_OFFSET: next_r.row_offset = reg_wdata;
        `FRS_OFF_BUF_ADDR:   next_r.buf_addr = reg_wdata[AW-1:0];
        `FRS_OFF_BUF_DATA_HI: next_r.buf_hi = reg_wdata[7:0];
        `FRS_OFF_BUF_DATA:   next_r.buf_addr = r.buf_addr + 1'b1;
        `FRS_OFF_MEM_CTRL: begin
          next_r.op_sel = reg_wdata[6:0];
          next_r.permit = reg_wdata[`FRS_BIT_PERMIT];
          // Start honoured only when armed, permitted and a row op
          if (reg_wdata[`FRS_BIT_START] && r.key_stage == 2'h2
              && reg_wdata[`FRS_BIT_PERMIT]
              && reg_wdata[5:0] == `FRS_OP_ROW) begin
            go = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // Cycle sequencing
    case (r.state)
      FRS_IDLE: begin
        if (go) begin
          next_r.state   = FRS_RUN;
          next_r.start   = 1'b1;
          next_r.stall   = 1'b1;
          next_r.erase_o = reg_wdata[`FRS_BIT_ERASE];
          next_r.prog_o  = !reg_wdata[`FRS_BIT_ERASE];
          next_r.count   = reg_wdata[`FRS_BIT_ERASE] ? ERASE_CYCLES : PROG_CYCLES;
          next_r.word    = '0;
          next_r.faddr   = row_base(r.table_page, r.row_offset);
        end
      end
      FRS_RUN: begin
        // Program: stream buffered row into the array, one word per cycle
        if (r.prog_o && r.word <= (AW+1)'(ROW_WORDS)) begin
          next_r.word = r.word + 1'b1;
          if (r.word != '0) begin
            next_r.fwr = 1'b1;
            next_r.faddr = row_base(r.table_page, r.row_offset) +
                           24'({r.word - 1'b1, 1'b0});
          end
        end
        if (r.count <= 32'd1) begin
          next_r.state = FRS_DONE;
        end else begin
          next_r.count = r.count - 32'd1;
        end
      end
      FRS_DONE: begin
        next_r.state   = FRS_IDLE;
        next_r.start   = 1'b0;
        next_r.stall   = 1'b0;
        next_r.erase_o = 1'b0;
        next_r.prog_o  = 1'b0;
        next_r.key_stage = 2'h0;
      end
      default: next_r.state = FRS_IDLE;
    endcase
    // Read data, valid the cycle after the strobe
    if (reg_rd) begin
      case (reg_addr)
        `FRS_OFF_TABLE_PAGE: next_r.rdata = r.table_page;
        `FRS_OFF_MEM_CTRL:   next_r.rdata = {r.start, r.permit, 7'h00, r.op_sel};
        `FRS_OFF_ROW_OFFSET: next_r.rdata = r.row_offset;
        `FRS_OFF_BUF_ADDR:   next_r.rdata = 16'(r.buf_addr);
        default:             next_r.rdata = 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Synchronous reset, then register the next state
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      r <= '0;
      r.state <= FRS_IDLE;
      r.table_page <= `FRS_RST_TABLE_PAGE;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata   = r.rdata;
  assign cpu_stall   = r.stall;
  assign flash_erase = r.erase_o;
  assign flash_prog  = r.prog_o;
  assign flash_addr  = r.faddr;
  assign flash_wr    = r.fwr;
  assign flash_wdata = buf_rdata;
endmodule // frs_sequencer
`default_nettype wire

// ===== shared/frs_consts.svh
`ifndef FRS_CONSTS_SVH
`define FRS_CONSTS_SVH
// ----------------------------------------------------------------
// Register offsets (register port byte addresses)
// ----------------------------------------------------------------
`define FRS_OFF_TABLE_PAGE   8'h32
`define FRS_OFF_MEM_CTRL     8'h40
`define FRS_OFF_UNLOCK_KEY   8'h42
`define FRS_OFF_ROW_OFFSET   8'h44
`define FRS_OFF_BUF_ADDR     8'h46
`define FRS_OFF_BUF_DATA     8'h48
`define FRS_OFF_BUF_DATA_HI  8'h4A
// ----------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------
`define FRS_BIT_ERASE        6
`define FRS_BIT_PERMIT       14
`define FRS_BIT_START        15
`define FRS_OP_ROW           6'h18
`define FRS_KEY_FIRST        8'h55
`define FRS_KEY_SECOND       8'hAA
`define FRS_ROW_WORDS        32
// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define FRS_RST_TABLE_PAGE   16'h0000
`define FRS_RST_MEM_CTRL     16'h0000
`define FRS_ERASE_TIME_US    3000
`define FRS_PROG_TIME_US     3000
`define FRS_CLK_MHZ          20
`endif

// ===== shared/frs_pkg.sv
`default_nettype none
package frs_pkg;
  typedef enum logic [2:0] {
    FRS_IDLE = 3'b001,
    FRS_RUN  = 3'b010,
    FRS_DONE = 3'b100
  } frs_state_type;
endpackage
`default_nettype wire

// ===== verif/frs_chk_asserts.sv
`include "frs_consts.svh"
`default_nettype none
module frs_chk
  import frs_pkg::*;
#(parameter int ERASE_CYCLES = 50, parameter int PROG_CYCLES = 50) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic cpu_stall,
  input wire logic flash_erase,
  input wire logic flash_prog,
  input wire logic flash_wr
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic k1, k2;
  int sc, wc;
  wire st = reg_wr && reg_addr == `FRS_OFF_MEM_CTRL && !cpu_stall;
  wire ok = reg_wdata[15:14] == 2'h3 && reg_wdata[5:0] == `FRS_OP_ROW;
  // Shadow of key arming, stall length and word count
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      k1 <= 1'b0;
      k2 <= 1'b0;
    end else if (reg_wr && !cpu_stall) begin
      k1 <= reg_addr == `FRS_OFF_UNLOCK_KEY && reg_wdata[7:0] == `FRS_KEY_FIRST;
      k2 <= reg_addr == `FRS_OFF_UNLOCK_KEY && reg_wdata[7:0] == `FRS_KEY_SECOND && k1;
    end
    sc <= cpu_stall ? sc + 1 : 0;
    wc <= flash_prog ? wc + int'(flash_wr) : 0;
  end
  a_refuse_lock: assert property (st && !k2 |=> !cpu_stall) else $error("start unlocked");
  a_refuse_perm: assert property (st && !reg_wdata[14] |=> !cpu_stall) else $error("no permit");
  a_refuse_op: assert property (st && reg_wdata[5:0] != `FRS_OP_ROW |=> !cpu_stall)
    else $error("bad op started");
  a_start_run: assert property (st && k2 && ok |=> cpu_stall && flash_erase == $past(reg_wdata[6])
    && flash_prog != $past(reg_wdata[6])) else $error("start wrong");
  a_kind_stall: assert property (flash_erase || flash_prog |-> cpu_stall) else $error("no stall");
  a_stall_len: assert property ($fell(cpu_stall) |->
    sc == ($past(flash_erase) ? ERASE_CYCLES : PROG_CYCLES) + 1) else $error("stall length");
  a_row_words: assert property ($fell(flash_prog) |-> wc == 32) else $error("word count");
  a_wr_prog: assert property (flash_wr |-> flash_prog) else $error("stray write");
  c_erase: cover property (st && k2 && ok && reg_wdata[6]);
  c_prog: cover property (st && k2 && ok && !reg_wdata[6]);
  c_refused: cover property (st && !k2);
endmodule // frs_chk
`default_nettype wire

// ===== verif/frs_flash_model.sv
`default_nettype none
module frs_flash_model
  import frs_pkg::*;
(
  input wire logic mclk,
  input wire logic flash_erase,
  input wire logic flash_prog,
  input wire logic flash_wr,
  input wire logic [23:0] flash_addr,
  input wire logic [23:0] flash_wdata,
  output logic [23:0] erase_row,
  output logic [23:0] last_word,
  output logic [23:0] last_addr,
  output var int words
);
  // Record erased row base and programmed words
  always_ff @(posedge mclk) begin
    if (flash_erase) erase_row <= flash_addr;
    if ($rose(flash_prog)) words <= 0;
    else if (flash_wr) begin
      words <= words + 1;
      last_word <= flash_wdata;
      last_addr <= flash_addr;
    end
  end
endmodule // frs_flash_model
`default_nettype wire

// ===== verif/tb.sv
`include "frs_consts.svh"
`default_nettype none
module tb import frs_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [15:0] a, b, c; logic e;} frs_row_type;
  localparam logic [7:0] CT = `FRS_OFF_MEM_CTRL, KY = `FRS_OFF_UNLOCK_KEY, TP = 8'h32;
  logic mclk = 1'h0, nrst = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, d;
  logic cpu_stall, flash_erase, flash_prog, flash_wr;
  logic [23:0] flash_addr, flash_wdata, erase_row, last_word, last_addr;
  int words, mismatches = 0, tests_run = 0;
  frs_row_type rows[6] = '{'{16'h55, 16'hAA, 16'hC058, 1'h1}, '{16'h0, 16'h0, 16'hC058, 1'h0},
    '{16'h55, 16'hAA, 16'h8058, 1'h0}, '{16'h55, 16'hAA, 16'hC059, 1'h0},
    '{16'hAA, 16'h55, 16'hC058, 1'h0}, '{16'h55, 16'hAA, 16'hC018, 1'h1}};
  always #25 mclk = ~mclk;
  frs_sequencer #(.ERASE_CYCLES(50), .PROG_CYCLES(50)) uut (.mclk(mclk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cpu_stall(cpu_stall), .flash_erase(flash_erase),
    .flash_prog(flash_prog), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .flash_wr(flash_wr));
  frs_flash_model far (.mclk(mclk), .flash_erase(flash_erase), .flash_prog(flash_prog),
    .flash_wr(flash_wr), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .erase_row(erase_row), .last_word(last_word), .last_addr(last_addr), .words(words));
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge mclk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'h0;
    @(negedge mclk);
    d = reg_rdata;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog
  initial begin
    #200000;
    mismatches++;
    summarize();
  end
  // Reset, start table, then disarm cases
  initial begin
    repeat (6) @(posedge mclk);
    nrst <= 1'h1;
    rd(TP);
    chk(d, 24'h0);
    rd(CT);
    chk(d, 24'h0);
    $display("test reset done");
    wr(TP, 16'h0012);
    wr(`FRS_OFF_ROW_OFFSET, 16'h0040);
    wr(`FRS_OFF_BUF_ADDR, 16'h0000);
    for (int i = 0; i < 32; i++) begin
      wr(`FRS_OFF_BUF_DATA_HI, 16'(i));
      wr(`FRS_OFF_BUF_DATA, 16'h1000 + 16'(i));
    end
    rd(`FRS_OFF_ROW_OFFSET);
    chk(d, 24'h40);
    rd(`FRS_OFF_BUF_ADDR);
    chk(d, 24'h0);
    foreach (rows[i]) begin
      wr(KY, rows[i].a);
      wr(KY, rows[i].b);
      wr(CT, rows[i].c);
      @(negedge mclk);
      chk(cpu_stall, rows[i].e);
      if (rows[i].e) begin
        repeat (2) @(negedge mclk);
        chk(flash_erase, rows[i].c[6]);
        chk(flash_prog, !rows[i].c[6]);
        repeat (200) if (cpu_stall) @(negedge mclk);
        rd(CT);
        chk(d[15], 1'h0);
        chk(d, rows[i].c & 16'h7FFF);
      end
      $display("test row %0d done", i);
    end
    chk(erase_row, 24'h120040);
    chk(24'(words), 24'h20);
    chk(last_word, 24'h1F101F);
    chk(last_addr, 24'h12007E);
    wr(CT, 16'hC058);
    @(negedge mclk);
    chk(cpu_stall, 1'h0);
    wr(KY, 16'h0055);
    wr(TP, 16'h0012);
    wr(KY, 16'h00AA);
    wr(CT, 16'hC058);
    @(negedge mclk);
    chk(cpu_stall, 1'h0);
    $display("test disarm done");
    // Reset in the middle of a program cycle
    wr(KY, 16'h0055);
    wr(KY, 16'h00AA);
    wr(CT, 16'hC018);
    @(negedge mclk);
    chk(cpu_stall, 1'h1);
    repeat (5) @(posedge mclk);
    nrst <= 1'h0;
    repeat (2) @(posedge mclk);
    nrst <= 1'h1;
    @(negedge mclk);
    chk(cpu_stall, 1'h0);
    rd(TP);
    chk(d, 24'h0);
    rd(CT);
    chk(d, 24'h0);
    $display("test mid reset done");
    summarize();
  end
endmodule // tb
bind frs_sequencer frs_chk #(.ERASE_CYCLES(ERASE_CYCLES), .PROG_CYCLES(PROG_CYCLES)) u_chk (
  .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .cpu_stall(cpu_stall), .flash_erase(flash_erase), .flash_prog(flash_prog),
  .flash_wr(flash_wr));
`default_nettype wire
